// [verilog/rx_output_pkg.sv]
// Purpose: shared constants and carriers for the receive output stage
// Assumes: four channels, each with its own recovered receive clock
// Notes: the channel count and the rail, flag, polarity and reset-chain reset values used by the design live here

package rx_output_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NUM_CHANNELS = 4;   // channels in the device
  localparam int RST_SYNC_LEN = 2;   // reset release stages per channel domain

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic RAIL_RST = 1'h0;            // rail outputs low
  localparam logic FLAG_RST = 1'h0;            // loss flag low
  localparam logic SYNC_RST = 1'h0;            // synchroniser stages
  localparam logic [1:0] RST_SYNC_RST = 2'h0;  // reset release chain

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // recovered line data, on the channel's recovered clock
  typedef struct packed {
    logic pos_pulse;     // positive-polarity pulse this bit
    logic neg_pulse;     // negative-polarity pulse this bit
    logic loss_detect;   // receiver logic sees loss of signal
    logic decode_cv;     // decoder-found violation (non-AMI codes)
  } rx_line_t;

  // per-channel output pins towards the framer
  typedef struct packed {
    logic positive_rail_out;    // pos rail or NRZ data
    logic negative_rail_out;    // neg rail or violation pulse
    logic loss_of_signal_flag;  // loss of signal
  } rx_pins_t;

  // configuration levels, as seen inside one channel domain
  typedef struct packed {
    logic single_rail;          // 1: NRZ plus violation pulse
    logic ami;                  // 1: AMI line coding
    logic mute_on_signal_loss;  // 1: force rails low on loss
  } rx_cfg_t;

  // polarity of the last mark seen (gray along none-pos-neg)
  typedef enum logic [1:0] {
    POL_NONE = 2'h0,
    POL_POS  = 2'h1,
    POL_NEG  = 2'h3
  } pulse_pol_t;

endpackage : rx_output_pkg

// [verilog/quad_line_receive_output.sv]
// Purpose: receive digital output stage of a four-channel line interface
// Assumes: line data and loss detect arrive on each recovered clock
// Notes: mode and mute inputs are asynchronous levels, resynchronised
//
// Contract
// - loss flag high at least one cycle
// - loss flag held while loss persists
// - dual-rail: negative rail carries negative pulses
// - single-rail: one-cycle pulse per code violation
// - AMI: every bipolar violation is a violation
// - dual-rail: positive rail carries positive pulses
// - single-rail: positive pin carries NRZ data
// - separate recovered clock output per channel
// - mute input with loss forces rails low

`timescale 1ns/10ps

module quad_line_receive_output #(
  parameter int NUM_CHANNELS = rx_output_pkg::NUM_CHANNELS
) (
  input wire logic core_clk,                      // system clock, 40 MHz
  input wire logic rst_n,                         // async reset, low
  input wire logic [NUM_CHANNELS-1:0] recovered_clk, // per-channel clock
  input wire rx_output_pkg::rx_line_t [NUM_CHANNELS-1:0] line_in, // data
  input wire logic single_rail_mode,              // async level
  input wire logic ami_coding,                    // async level
  input wire logic mute_on_signal_loss,           // async level
  output logic [NUM_CHANNELS-1:0] recovered_clk_out, // clock to framer
  output rx_output_pkg::rx_pins_t [NUM_CHANNELS-1:0] rx_out, // framer pins
  output logic [NUM_CHANNELS-1:0] los_status      // loss, core domain
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // a synchronised level moves only once stages two and three agree
  function automatic logic agree(input logic s2, input logic s3,
                                 input logic held);
    agree = (s2 == s3) ? s3 : held;
  endfunction : agree

  // ---------------------------------------------------------------
  // per-channel receive output
  // ---------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan

      logic [1:0] rst_chain_reg;     // reset release chain
      logic ch_rst_n;                // channel domain reset
      rx_output_pkg::rx_cfg_t cfg_s1_reg; // first stage, read by s2 only
      rx_output_pkg::rx_cfg_t cfg_s2_reg; // second stage
      rx_output_pkg::rx_cfg_t cfg_s3_reg; // third stage
      rx_output_pkg::rx_cfg_t cfg_reg;    // settled configuration
      rx_output_pkg::pulse_pol_t last_pol_reg; // last mark polarity
      logic bpv;                     // bipolar violation this bit
      logic cv_now;                  // code violation this bit
      logic muted;                   // rails forced low this bit
      logic pos_next;                // next positive pin value
      logic neg_next;                // next negative pin value
      logic pos_reg;                 // positive pin register
      logic neg_reg;                 // negative pin register
      logic los_reg;                 // loss flag register

      assign recovered_clk_out[ch] = recovered_clk[ch];

      // reset asserts at once, releases on this channel's clock
      always_ff @(posedge recovered_clk[ch] or negedge rst_n) begin
        if (!rst_n) begin
          rst_chain_reg <= rx_output_pkg::RST_SYNC_RST;
        end else begin
          rst_chain_reg <= {rst_chain_reg[0], 1'h1};
        end
      end
      assign ch_rst_n = rst_chain_reg[1];

      // three-stage capture of the asynchronous configuration
      always_ff @(posedge recovered_clk[ch] or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
          cfg_s1_reg <= '0;
          cfg_s2_reg <= '0;
          cfg_s3_reg <= '0;
        end else begin
          cfg_s1_reg <= {single_rail_mode, ami_coding,
                         mute_on_signal_loss};
          cfg_s2_reg <= cfg_s1_reg;
          cfg_s3_reg <= cfg_s2_reg;
        end
      end

      // settled configuration, updated on agreement only
      always_ff @(posedge recovered_clk[ch] or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
          cfg_reg <= '0;
        end else begin
          cfg_reg.single_rail <= agree(cfg_s2_reg.single_rail,
                                       cfg_s3_reg.single_rail,
                                       cfg_reg.single_rail);
          cfg_reg.ami <= agree(cfg_s2_reg.ami, cfg_s3_reg.ami,
                               cfg_reg.ami);
          cfg_reg.mute_on_signal_loss <=
            agree(cfg_s2_reg.mute_on_signal_loss,
                  cfg_s3_reg.mute_on_signal_loss,
                  cfg_reg.mute_on_signal_loss);
        end
      end

      // track polarity of the last mark for bipolar checking
      always_ff @(posedge recovered_clk[ch] or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
          last_pol_reg <= rx_output_pkg::POL_NONE;
        end else if (line_in[ch].pos_pulse) begin
          last_pol_reg <= rx_output_pkg::POL_POS;
        end else if (line_in[ch].neg_pulse) begin
          last_pol_reg <= rx_output_pkg::POL_NEG;
        end
      end

      // same polarity twice is a violation
      assign bpv = (line_in[ch].pos_pulse && line_in[ch].neg_pulse) ||
                   (line_in[ch].pos_pulse &&
                    last_pol_reg == rx_output_pkg::POL_POS) ||
                   (line_in[ch].neg_pulse &&
                    last_pol_reg == rx_output_pkg::POL_NEG);
      // other codes take the decoder's verdict
      assign cv_now = cfg_reg.ami ? bpv : line_in[ch].decode_cv;

      // mute gates both rails on loss
      assign muted = cfg_reg.mute_on_signal_loss && line_in[ch].loss_detect;

      // output selection by rail mode
      always_comb begin
        pos_next = rx_output_pkg::RAIL_RST;
        neg_next = rx_output_pkg::RAIL_RST;
        if (muted) begin
          // both rails held low
          pos_next = rx_output_pkg::RAIL_RST;
          neg_next = rx_output_pkg::RAIL_RST;
        end else if (cfg_reg.single_rail) begin
          pos_next = line_in[ch].pos_pulse | line_in[ch].neg_pulse;
          neg_next = cv_now;
        end else begin
          pos_next = line_in[ch].pos_pulse;
          neg_next = line_in[ch].neg_pulse;
        end
      end

      always_ff @(posedge recovered_clk[ch] or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
          pos_reg <= rx_output_pkg::RAIL_RST;
          neg_reg <= rx_output_pkg::RAIL_RST;
        end else begin
          pos_reg <= pos_next;
          neg_reg <= neg_next;
        end
      end

      // loss flag follows detect per cycle
      always_ff @(posedge recovered_clk[ch] or negedge ch_rst_n) begin
        if (!ch_rst_n) begin
          los_reg <= rx_output_pkg::FLAG_RST;
        end else begin
          los_reg <= line_in[ch].loss_detect;
        end
      end

      assign rx_out[ch].positive_rail_out = pos_reg;
      assign rx_out[ch].negative_rail_out = neg_reg;
      assign rx_out[ch].loss_of_signal_flag = los_reg;

      // -------------------------------------------------------------
      // checks
      // -------------------------------------------------------------
      // sampled ch_rst_n skips the release edge, still held in reset
      property p_los_rise;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        ch_rst_n && $rose(line_in[ch].loss_detect) |=> los_reg;
      endproperty
      a_los_rise: assert property (p_los_rise)
        else $error("loss flag missed a new loss");

      property p_los_hold;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (ch_rst_n && line_in[ch].loss_detect) [*2] |=>
          los_reg && $past(los_reg);
      endproperty
      a_los_hold: assert property (p_los_hold)
        else $error("loss flag dropped during loss");

      property p_dual_neg;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (!cfg_reg.single_rail && !muted) |=>
          neg_reg == $past(line_in[ch].neg_pulse);
      endproperty
      a_dual_neg: assert property (p_dual_neg)
        else $error("negative rail not following negative pulses");

      property p_single_cv;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (cfg_reg.single_rail && !muted) |=> neg_reg == $past(cv_now);
      endproperty
      a_single_cv: assert property (p_single_cv)
        else $error("violation pulse wrong in single-rail mode");

      property p_ami_bpv;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (cfg_reg.single_rail && cfg_reg.ami && !muted &&
         line_in[ch].pos_pulse && last_pol_reg == rx_output_pkg::POL_POS)
          |=> neg_reg;
      endproperty
      a_ami_bpv: assert property (p_ami_bpv)
        else $error("AMI bipolar violation not flagged");

      property p_dual_pos;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (!cfg_reg.single_rail && !muted) |=>
          pos_reg == $past(line_in[ch].pos_pulse);
      endproperty
      a_dual_pos: assert property (p_dual_pos)
        else $error("positive rail not following positive pulses");

      property p_single_nrz;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (cfg_reg.single_rail && !muted) |=>
          pos_reg == ($past(line_in[ch].pos_pulse) ||
                      $past(line_in[ch].neg_pulse));
      endproperty
      a_single_nrz: assert property (p_single_nrz)
        else $error("NRZ data wrong in single-rail mode");

      property p_mute;
        @(posedge recovered_clk[ch]) disable iff (!ch_rst_n)
        (cfg_reg.mute_on_signal_loss && line_in[ch].loss_detect) |=>
          !pos_reg && !neg_reg && los_reg;
      endproperty
      a_mute: assert property (p_mute)
        else $error("rails not muted on loss");

    end
  endgenerate

  // ---------------------------------------------------------------
  // loss status into the core clock domain
  // ---------------------------------------------------------------
  logic [NUM_CHANNELS-1:0] los_s1_reg;   // first stage, read by s2 only
  logic [NUM_CHANNELS-1:0] los_s2_reg;   // second stage
  logic [NUM_CHANNELS-1:0] los_s3_reg;   // third stage
  logic [NUM_CHANNELS-1:0] los_flags;    // loss flags from each channel

  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_los_tap
      assign los_flags[ch] = rx_out[ch].loss_of_signal_flag;
    end
  endgenerate

  // three-stage capture of the channel loss flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      los_s1_reg <= '0;
      los_s2_reg <= '0;
      los_s3_reg <= '0;
    end else begin
      los_s1_reg <= los_flags;
      los_s2_reg <= los_s1_reg;
      los_s3_reg <= los_s2_reg;
    end
  end

  // status moves once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      los_status <= '0;
    end else begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        los_status[i] <= agree(los_s2_reg[i], los_s3_reg[i],
                               los_status[i]);
      end
    end
  end

endmodule : quad_line_receive_output

// [dv/framer_model.sv]
// Purpose: framer-side model sampling receive pins on their own clocks
// Assumes: pins settle after each rising edge of the recovered clock
// Notes: counts marks seen on the positive pin of every channel

`timescale 1ns/10ps

module framer_model (
  input wire logic [3:0] rclk,                    // clocks from device
  input wire rx_output_pkg::rx_pins_t [3:0] pins, // receive pins
  input wire logic clear,                         // zero the counters
  output logic [15:0] marks [4]                   // marks per channel
);
  // ---------------------------------------------------------------
  // sampling on each channel clock
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 4; ch++) begin : g_ch
    always @(posedge rclk[ch] or posedge clear) begin
      if (clear) begin
        marks[ch] <= 16'h0000;
      end else if (pins[ch].positive_rail_out === 1'b1) begin
        marks[ch] <= marks[ch] + 16'h0001;
      end
    end
  end
endmodule : framer_model

// [dv/test_quad_line_receive_output.sv]
// Purpose: self-checking bench for the four-channel receive output stage
// Assumes: per-channel clocks of 6 ns, core clock of 25 ns
// Notes: a reference model predicts every pin at every channel edge

`timescale 1ns/10ps

module test_quad_line_receive_output;
  localparam int NCH = rx_output_pkg::NUM_CHANNELS; // channel count
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk, rst_n;                       // core clock and reset
  logic [NCH-1:0] lclk;                        // recovered clocks
  rx_output_pkg::rx_line_t [NCH-1:0] line;     // line data to device
  logic single_rail_mode, ami_coding, mute_on_signal_loss; // config
  logic [NCH-1:0] recovered_clk_out, los_status; // device outputs
  rx_output_pkg::rx_pins_t [NCH-1:0] rx_out;   // receive pins
  logic quiet, force_loss, clear;              // bench controls
  logic [15:0] fr_marks [4];                   // framer counts
  int exp_marks [NCH];                         // model counts
  int err_count, n_tests, seed;                // bookkeeping

  quad_line_receive_output DUT (.core_clk(core_clk), .rst_n(rst_n),
    .recovered_clk(lclk), .line_in(line),
    .single_rail_mode(single_rail_mode), .ami_coding(ami_coding),
    .mute_on_signal_loss(mute_on_signal_loss),
    .recovered_clk_out(recovered_clk_out), .rx_out(rx_out),
    .los_status(los_status));
  framer_model frm (.rclk(recovered_clk_out), .pins(rx_out),
    .clear(clear), .marks(fr_marks));

  // ---------------------------------------------------------------
  // clocks
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // compare and count
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // print counts and verdict, end the run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // per-channel stimulus and reference model
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    int last;                        // last mark: 0 none 1 pos 2 neg
    logic p, n, v, m;                // marks, violation, muted
    logic [31:0] r;                  // random draw
    rx_output_pkg::rx_pins_t exp;    // predicted pins
    // phases offset so only channel 2 edges ever meet a core falling edge
    initial begin
      lclk[ch] = 1'b0;
      #(0.2 + 0.4 * ch);
      forever #3 lclk[ch] = ~lclk[ch];
    end
    // predict pins from the sample taken at this edge
    always @(posedge lclk[ch] or negedge rst_n) begin
      if (!rst_n) begin
        last = 0;
        exp = '0;
      end else begin
        p = line[ch].pos_pulse;
        n = line[ch].neg_pulse;
        v = ami_coding ? ((p && last == 1) || (n && last == 2))
                       : line[ch].decode_cv;
        m = mute_on_signal_loss && line[ch].loss_detect;
        exp.positive_rail_out = !m && (single_rail_mode ? (p | n) : p);
        exp.negative_rail_out = !m && (single_rail_mode ? v : n);
        exp.loss_of_signal_flag = line[ch].loss_detect;
        if (p) last = 1;
        else if (n) last = 2;
        if (exp.positive_rail_out) exp_marks[ch]++;
      end
    end
    // compare settled pins, then drive the next bit
    always @(negedge lclk[ch]) begin
      if (!quiet) begin
        check("positive_rail_out", rx_out[ch].positive_rail_out,
              exp.positive_rail_out);
        check("negative_rail_out", rx_out[ch].negative_rail_out,
              exp.negative_rail_out);
        check("loss_of_signal_flag", rx_out[ch].loss_of_signal_flag,
              exp.loss_of_signal_flag);
      end
      r = $random(seed);
      line[ch].pos_pulse <= !quiet && r[0];
      line[ch].neg_pulse <= !quiet && r[1] && !r[0];
      line[ch].loss_detect <= force_loss || (!quiet && r[4:2] == 3'h0);
      line[ch].decode_cv <= !quiet && r[5];
    end
  end

  // ---------------------------------------------------------------
  // main sequence: every mode, coding and mute combination
  // ---------------------------------------------------------------
  initial begin
    seed = 61955;
    {rst_n, quiet, force_loss, clear} = 4'h5;
    rst_n = 1'b0;
    {single_rail_mode, ami_coding, mute_on_signal_loss} = 3'h0;
    line = '0;
    err_count = 0;
    n_tests = 0;
    exp_marks = '{default: 0};
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    clear = 1'b0;
    for (int t = 0; t < 8; t++) begin
      {single_rail_mode, ami_coding, mute_on_signal_loss} = t[2:0];
      repeat (4) @(negedge core_clk);
      quiet = 1'b0;
      repeat (200) begin
        @(negedge core_clk);
        check("recovered_clk_out", recovered_clk_out, lclk);
      end
      quiet = 1'b1;
      repeat (4) @(negedge core_clk);
      for (int ch = 0; ch < NCH; ch++) begin
        check("framer marks", fr_marks[ch], exp_marks[ch]);
      end
      clear = 1'b1;
      exp_marks = '{default: 0};
      @(negedge core_clk);
      clear = 1'b0;
      $display("test mode %0d done", t);
    end
    // long loss crosses to the core domain
    force_loss = 1'b1;
    repeat (8) @(negedge core_clk);
    check("los_status high", los_status, 4'hf);
    force_loss = 1'b0;
    repeat (8) @(negedge core_clk);
    check("los_status low", los_status, 4'h0);
    $display("test loss status done");
    complete_run();
  end

  // watchdog well beyond the expected run time
  initial begin
    #100000;
    $display("watchdog expired");
    err_count++;
    complete_run();
  end
endmodule : test_quad_line_receive_output
